// ===== design/bwc_pkg.sv
// Constants, field layout and carrier types for the bridge window configuration slice
package bwc_pkg;
	localparam int           APB_AW          = 12;
	// Register byte offsets
	localparam logic [11:0]  OFF_MEM_WIN     = 12'h020;
	localparam logic [11:0]  OFF_PF_WIN      = 12'h024;
	localparam logic [11:0]  OFF_PF_BASE_HI  = 12'h028;
	localparam logic [11:0]  OFF_PF_LIM_HI   = 12'h02c;
	localparam logic [11:0]  OFF_IO_HI       = 12'h030;
	localparam logic [11:0]  OFF_CAP         = 12'h034;
	localparam logic [11:0]  OFF_ROM         = 12'h038;
	localparam logic [11:0]  OFF_IRQ_CTL     = 12'h03c;
	localparam int           NUM_REGS        = 8;
	// Word indexes inside the slice
	localparam logic [2:0]   IDX_MEM_WIN     = 3'h0;
	localparam logic [2:0]   IDX_PF_WIN      = 3'h1;
	localparam logic [2:0]   IDX_PF_BASE_HI  = 3'h2;
	localparam logic [2:0]   IDX_PF_LIM_HI   = 3'h3;
	localparam logic [2:0]   IDX_IO_HI       = 3'h4;
	localparam logic [2:0]   IDX_CAP         = 3'h5;
	localparam logic [2:0]   IDX_ROM         = 3'h6;
	localparam logic [2:0]   IDX_IRQ_CTL     = 3'h7;
	// Writable bits per word, index 7 down to 0
	localparam logic [NUM_REGS-1:0][31:0] REG_WMASK = {
		32'h001f_00ff, 32'h0000_0000, 32'h0000_0000, 32'hffff_ffff,
		32'hffff_ffff, 32'hffff_ffff, 32'hfff0_fff0, 32'hfff0_fff0};
	// Fixed read-only values and reset values of writable bits, index 7 down to 0
	localparam logic [NUM_REGS-1:0][31:0] REG_FIXED = {
		32'h0000_0100, 32'h0000_0000, 32'h0000_0080, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000, 32'h0001_0001, 32'h0000_0000};
	localparam logic [7:0]   CAP_NORMAL      = 8'h80;
	localparam logic [7:0]   CAP_LEGACY      = 8'h90;
	// Bridge control bit positions
	localparam int           CTL_PERR_BIT    = 16;
	localparam int           CTL_SERR_BIT    = 17;
	localparam int           CTL_ISA_BIT     = 18;
	localparam int           CTL_VGA_BIT     = 19;
	localparam int           CTL_VGA16_BIT   = 20;
	// VGA legacy decode ranges
	localparam logic [15:0]  VGA_IO_MONO_LO  = 16'h03b0;
	localparam logic [15:0]  VGA_IO_MONO_HI  = 16'h03bb;
	localparam logic [15:0]  VGA_IO_COL_LO   = 16'h03c0;
	localparam logic [15:0]  VGA_IO_COL_HI   = 16'h03df;
	localparam logic [31:0]  VGA_MEM_LO      = 32'h000a_0000;
	localparam logic [31:0]  VGA_MEM_HI      = 32'h000b_ffff;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [APB_AW-1:0] paddr;
		logic [31:0]       pwdata;
		logic [3:0]        pstrb;
	} bwc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} bwc_apb_rsp_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} bwc_io_req_t;

	typedef struct packed {
		logic        valid;
		logic [63:0] addr;
	} bwc_mem_req_t;

	typedef struct packed {
		logic valid;
		logic down;
		logic up;
	} bwc_fwd_t;
endpackage : bwc_pkg

// ===== design/bwc_regs.sv
// Bridge window configuration registers with APB access and forwarding decode
`timescale 1ns/1ns
module bwc_regs (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire bwc_pkg::bwc_apb_req_t apb_req,
	output bwc_pkg::bwc_apb_rsp_t      apb_rsp,
	input  wire logic                  legacy_mode_in,
	input  wire logic                  io_space_en,
	input  wire logic                  mem_space_en,
	input  wire logic [3:0]            io_base_nibble,
	input  wire logic [3:0]            io_limit_nibble,
	input  wire bwc_pkg::bwc_io_req_t  io_lookup,
	input  wire bwc_pkg::bwc_mem_req_t mem_lookup,
	output bwc_pkg::bwc_fwd_t          io_fwd,
	output bwc_pkg::bwc_fwd_t          mem_fwd,
	input  wire logic                  sec_parity_err,
	output logic                       parity_err_report,
	input  wire logic                  system_error_pin_n,
	output logic                       syserr_msg_req
);
	import bwc_pkg::*;

	logic [31:0]               regs_q [NUM_REGS];
	logic [31:0]               prdata_q;
	logic                      pready_q;
	logic                      pslverr_q;
	logic                      leg_s1_q;
	logic                      leg_q;
	logic                      serr_s1_q;
	logic                      serr_s2_q;
	logic                      serr_prev_q;
	bwc_fwd_t                  io_fwd_q;
	bwc_fwd_t                  mem_fwd_q;
	logic                      perr_q;
	logic                      serr_msg_q;

	// Bus decode
	wire logic [2:0]  idx       = apb_req.paddr[4:2];
	wire logic        in_range  = (apb_req.paddr[APB_AW-1:5] == OFF_MEM_WIN[APB_AW-1:5]);
	wire logic        setup     = apb_req.psel & ~apb_req.penable;
	wire logic        wr_fire   = apb_req.psel & apb_req.penable & apb_req.pwrite & pready_q;
	wire logic [31:0] strb_mask = {{8{apb_req.pstrb[3]}}, {8{apb_req.pstrb[2]}},
	                               {8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};
	wire logic [7:0]  cap_ptr   = leg_q ? CAP_LEGACY : CAP_NORMAL;
	wire logic [31:0] rd_word   = (idx == IDX_CAP) ? {24'h000000, cap_ptr} : regs_q[idx];

	// Named fields of the stored words
	wire logic [11:0] mem_base12 = regs_q[IDX_MEM_WIN][15:4];
	wire logic [11:0] mem_lim12  = regs_q[IDX_MEM_WIN][31:20];
	wire logic [11:0] pf_base12  = regs_q[IDX_PF_WIN][15:4];
	wire logic [11:0] pf_lim12   = regs_q[IDX_PF_WIN][31:20];
	wire logic [15:0] io_base_hi = regs_q[IDX_IO_HI][15:0];
	wire logic [15:0] io_lim_hi  = regs_q[IDX_IO_HI][31:16];
	wire logic [31:0] ctl        = regs_q[IDX_IRQ_CTL];
	wire logic        perr_en    = ctl[CTL_PERR_BIT];
	wire logic        syserr_forward_en     = ctl[CTL_SERR_BIT];
	wire logic        isa_alias_upstream_en = ctl[CTL_ISA_BIT];
	wire logic        vga_en     = ctl[CTL_VGA_BIT];
	wire logic        vga16      = ctl[CTL_VGA16_BIT];

	// Storage words, one writer per entry; fixed bits reloaded on reset and on every write
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
		wire logic        hit  = wr_fire & in_range & (idx == 3'(i));
		wire logic [31:0] mrg  = (regs_q[i] & ~strb_mask) | (apb_req.pwdata & strb_mask);
		wire logic [31:0] wr_d = (mrg & REG_WMASK[i]) | (REG_FIXED[i] & ~REG_WMASK[i]);
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				regs_q[i] <= REG_FIXED[i];
			else if (hit)
				regs_q[i] <= wr_d;
		end
	end

	// APB answer: one wait-free access phase after each setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= setup;
			pslverr_q <= setup & ~in_range;
			if (setup)
				prdata_q <= (in_range && !apb_req.pwrite) ? rd_word : 32'h00000000;
		end
	end

	// Pin synchronisers for legacy mode and the system error pin
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			leg_s1_q    <= 1'b0;
			leg_q       <= 1'b0;
			serr_s1_q   <= 1'b1;
			serr_s2_q   <= 1'b1;
			serr_prev_q <= 1'b1;
		end
		else
		begin
			leg_s1_q    <= legacy_mode_in;
			leg_q       <= leg_s1_q;
			serr_s1_q   <= system_error_pin_n;
			serr_s2_q   <= serr_s1_q;
			serr_prev_q <= serr_s2_q;
		end
	end

	// I/O window and ISA alias decode
	wire logic [31:0] io_a      = io_lookup.addr;
	wire logic [31:0] io_base   = {io_base_hi, io_base_nibble, 12'h000};
	wire logic [31:0] io_limit  = {io_lim_hi, io_limit_nibble, 12'hfff};
	wire logic        io_in_win = io_space_en && (io_a >= io_base) && (io_a <= io_limit);
	wire logic        isa_alias = isa_alias_upstream_en && (io_a[31:16] == 16'h0000)
	                              && (io_a[9:8] != 2'b00);
	wire logic [15:0] vga_io_a  = vga16 ? io_a[15:0] : {6'h00, io_a[9:0]};
	wire logic        vga_io_ok = vga16 ? (io_a[31:16] == 16'h0000) : 1'b1;
	wire logic        vga_io    = vga_en && io_space_en && vga_io_ok &&
	                              (((vga_io_a >= VGA_IO_MONO_LO) && (vga_io_a <= VGA_IO_MONO_HI)) ||
	                               ((vga_io_a >= VGA_IO_COL_LO) && (vga_io_a <= VGA_IO_COL_HI)));
	wire logic        io_down   = vga_io || (io_in_win && !isa_alias);
	wire logic        io_up     = !vga_io && io_in_win && isa_alias;

	// Memory and prefetchable window decode
	wire logic [63:0] mem_a     = mem_lookup.addr;
	wire logic        mem_low   = (mem_a[63:32] == 32'h00000000);
	wire logic [31:0] mem_base  = {mem_base12, 20'h00000};
	wire logic [31:0] mem_limit = {mem_lim12, 20'hfffff};
	wire logic [63:0] pf_base   = {regs_q[IDX_PF_BASE_HI], pf_base12, 20'h00000};
	wire logic [63:0] pf_limit  = {regs_q[IDX_PF_LIM_HI], pf_lim12, 20'hfffff};
	wire logic        mem_in_w  = mem_low && (mem_a[31:0] >= mem_base) && (mem_a[31:0] <= mem_limit);
	wire logic        pf_in_w   = (mem_a >= pf_base) && (mem_a <= pf_limit);
	wire logic        vga_mem   = vga_en && mem_low &&
	                              (mem_a[31:0] >= VGA_MEM_LO) && (mem_a[31:0] <= VGA_MEM_HI);
	wire logic        mem_down  = mem_space_en && (mem_in_w || pf_in_w || vga_mem);

	// Registered forwarding decisions
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			io_fwd_q  <= '0;
			mem_fwd_q <= '0;
		end
		else
		begin
			io_fwd_q  <= '{valid: io_lookup.valid, down: io_lookup.valid & io_down,
			               up: io_lookup.valid & io_up};
			mem_fwd_q <= '{valid: mem_lookup.valid, down: mem_lookup.valid & mem_down, up: 1'b0};
		end
	end

	// Secondary error reporting gates
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			perr_q     <= 1'b0;
			serr_msg_q <= 1'b0;
		end
		else
		begin
			perr_q     <= sec_parity_err & perr_en;
			serr_msg_q <= ~serr_s2_q & serr_prev_q & syserr_forward_en;
		end
	end

	// Output drive
	assign apb_rsp           = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};
	assign io_fwd            = io_fwd_q;
	assign mem_fwd           = mem_fwd_q;
	assign parity_err_report = perr_q;
	assign syserr_msg_req    = serr_msg_q;

	// Checks on the logic above
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Qualified bus events used by the checks
	wire logic chk_rd   = setup & in_range & ~apb_req.pwrite;
	wire logic chk_wr   = wr_fire & in_range;
	wire logic chk_full = chk_wr & (apb_req.pstrb == 4'hf);

	a_pf_fixed_bits: assert property (regs_q[IDX_PF_WIN][3:0] == 4'h1 &&
		regs_q[IDX_PF_WIN][19:16] == 4'h1) else $error("prefetch fixed bits wrong");
	a_pf_base_write: assert property (wr_fire && in_range && idx == IDX_PF_BASE_HI &&
		apb_req.pstrb == 4'hf |=> regs_q[IDX_PF_BASE_HI] == $past(apb_req.pwdata))
		else $error("prefetch base upper write lost");
	a_strobe_keep: assert property (wr_fire && in_range && idx == IDX_PF_LIM_HI &&
		!apb_req.pstrb[0] |=> regs_q[IDX_PF_LIM_HI][7:0] == $past(regs_q[IDX_PF_LIM_HI][7:0]))
		else $error("disabled byte changed");
	a_rom_zero: assert property (setup && in_range && idx == IDX_ROM
		|=> prdata_q == 32'h00000000 && pready_q) else $error("option rom not zero");
	a_cap_value: assert property (setup && in_range && !apb_req.pwrite && idx == IDX_CAP
		|=> prdata_q == {24'h000000, ($past(leg_q) ? 8'h90 : 8'h80)})
		else $error("capability pointer wrong");
	a_irq_pin: assert property (regs_q[IDX_IRQ_CTL][15:8] == 8'h01 &&
		regs_q[IDX_IRQ_CTL][31:21] == 11'h000) else $error("interrupt pin byte wrong");
	a_ro_words: assert property ($stable(regs_q[IDX_CAP]) && $stable(regs_q[IDX_ROM]))
		else $error("read-only word changed");
	a_parity_gate: assert property (perr_q |-> $past(perr_en) && $past(sec_parity_err))
		else $error("parity report without enable");
	a_serr_gate: assert property (serr_msg_q |-> $past(syserr_forward_en))
		else $error("system error forwarded while disabled");
	a_isa_upstream: assert property (io_fwd_q.up |-> $past(isa_alias_upstream_en) &&
		!io_fwd_q.down) else $error("upstream without alias enable");
	a_ready_pulse: assert property (setup |=> pready_q ##1 !pready_q)
		else $error("ready not a single cycle");

	// Storage, bus answer, error gate and forwarding checks
	a_mem_low_zero: assert property (
		regs_q[IDX_MEM_WIN][3:0] == 4'h0 &&
		regs_q[IDX_MEM_WIN][19:16] == 4'h0)
		else $error("memory window low bits not zero");

	a_mem_win_write: assert property (
		chk_full && idx == IDX_MEM_WIN
		|=> regs_q[IDX_MEM_WIN] == ($past(apb_req.pwdata) & 32'hfff0_fff0))
		else $error("memory window write wrong");

	a_pf_win_write: assert property (
		chk_full && idx == IDX_PF_WIN
		|=> regs_q[IDX_PF_WIN] == (($past(apb_req.pwdata) & 32'hfff0_fff0) | 32'h0001_0001))
		else $error("prefetch window write wrong");

	a_pf_lim_write: assert property (
		chk_full && idx == IDX_PF_LIM_HI
		|=> regs_q[IDX_PF_LIM_HI] == $past(apb_req.pwdata))
		else $error("prefetch limit upper write lost");

	a_io_hi_write: assert property (
		chk_full && idx == IDX_IO_HI
		|=> regs_q[IDX_IO_HI] == $past(apb_req.pwdata))
		else $error("io upper window write lost");

	a_irq_line_write: assert property (
		chk_wr && idx == IDX_IRQ_CTL && apb_req.pstrb[0]
		|=> regs_q[IDX_IRQ_CTL][7:0] == $past(apb_req.pwdata[7:0]))
		else $error("interrupt routing byte write lost");

	a_ctl_bits_write: assert property (
		chk_wr && idx == IDX_IRQ_CTL && apb_req.pstrb[2]
		|=> regs_q[IDX_IRQ_CTL][20:16] == $past(apb_req.pwdata[20:16]))
		else $error("bridge control bits write lost");

	a_io_hi_strobe: assert property (
		chk_wr && idx == IDX_IO_HI && !apb_req.pstrb[3]
		|=> regs_q[IDX_IO_HI][31:24] == $past(regs_q[IDX_IO_HI][31:24]))
		else $error("disabled upper byte changed");

	a_hold_no_write: assert property (
		!chk_wr |=> regs_q[IDX_IO_HI] == $past(regs_q[IDX_IO_HI]) &&
		regs_q[IDX_PF_BASE_HI] == $past(regs_q[IDX_PF_BASE_HI]))
		else $error("register changed without write");

	a_slverr_out: assert property (
		setup && !in_range
		|=> pslverr_q && pready_q && prdata_q == 32'h00000000)
		else $error("out of range access not refused");

	a_slverr_in: assert property (
		setup && in_range
		|=> !pslverr_q)
		else $error("in range access refused");

	a_irq_pin_read: assert property (
		chk_rd && idx == IDX_IRQ_CTL
		|=> prdata_q[15:8] == 8'h01 && prdata_q[31:21] == 11'h000)
		else $error("interrupt pin read wrong");

	a_pf_read_fixed: assert property (
		chk_rd && idx == IDX_PF_WIN
		|=> prdata_q[3:0] == 4'h1 && prdata_q[19:16] == 4'h1)
		else $error("prefetch fixed bits read wrong");

	a_perr_follow: assert property (
		sec_parity_err && perr_en
		|=> perr_q)
		else $error("parity error not reported");

	a_perr_quiet: assert property (
		!perr_en
		|=> !perr_q)
		else $error("parity error reported while disabled");

	a_serr_follow: assert property (
		!serr_s2_q && serr_prev_q && syserr_forward_en
		|=> serr_msg_q)
		else $error("system error not forwarded");

	a_serr_quiet: assert property (
		!syserr_forward_en
		|=> !serr_msg_q)
		else $error("system error message while disabled");

	a_isa_off_down: assert property (
		io_lookup.valid && io_in_win && !isa_alias_upstream_en
		|=> io_fwd_q.down && !io_fwd_q.up)
		else $error("window io not forwarded down");

	a_isa_alias_up: assert property (
		io_lookup.valid && io_in_win && isa_alias_upstream_en && !vga_en &&
		io_a[31:16] == 16'h0000 && io_a[9:8] != 2'b00 |=> io_fwd_q.up)
		else $error("aliased io not sent upstream");

	a_isa_low_down: assert property (
		io_lookup.valid && io_in_win && io_a[9:8] == 2'b00
		|=> io_fwd_q.down && !io_fwd_q.up)
		else $error("low quarter io not forwarded down");

	a_vga_off_io: assert property (
		io_lookup.valid && !vga_en && !io_in_win
		|=> !io_fwd_q.down && !io_fwd_q.up)
		else $error("io outside window forwarded");

	a_vga_off_mem: assert property (
		mem_lookup.valid && !vga_en && !mem_in_w && !pf_in_w
		|=> !mem_fwd_q.down)
		else $error("memory outside windows forwarded");

	a_vga_mem_on: assert property (
		mem_lookup.valid && vga_en && mem_space_en && mem_a[63:32] == 32'h00000000 &&
		mem_a[31:0] >= VGA_MEM_LO && mem_a[31:0] <= VGA_MEM_HI |=> mem_fwd_q.down)
		else $error("vga memory not forwarded");

	a_vga_io_on: assert property (
		io_lookup.valid && vga_en && !vga16 && io_space_en &&
		io_a[9:0] >= 10'h3c0 && io_a[9:0] <= 10'h3df |=> io_fwd_q.down && !io_fwd_q.up)
		else $error("vga io not forwarded");

	a_vga_sixteen: assert property (
		io_lookup.valid && vga_en && vga16 && io_a[15:10] != 6'h00 && !io_in_win
		|=> !io_fwd_q.down)
		else $error("16-bit decode matched an alias");

	a_io_en_gate: assert property (
		!io_space_en
		|=> !io_fwd_q.down && !io_fwd_q.up)
		else $error("io forwarded while io space off");

	a_mem_en_gate: assert property (
		!mem_space_en
		|=> !mem_fwd_q.down)
		else $error("memory forwarded while memory space off");

	a_pf_above_lim: assert property (
		mem_lookup.valid && mem_a[63:32] > regs_q[IDX_PF_LIM_HI]
		|=> !mem_fwd_q.down)
		else $error("address above prefetch limit forwarded");

	a_pf_below_base: assert property (
		mem_lookup.valid && mem_a[63:32] != 32'h00000000 && mem_a[63:32] < regs_q[IDX_PF_BASE_HI]
		|=> !mem_fwd_q.down)
		else $error("address below prefetch base forwarded");

	c_write: cover property (wr_fire && in_range);
	c_cap_legacy: cover property (setup && idx == IDX_CAP && leg_q);
	c_io_up: cover property (io_fwd_q.up);
	c_serr_msg: cover property (serr_msg_q);
	c_vga_down: cover property (io_fwd_q.down && vga_en);
endmodule : bwc_regs

// ===== testbench/bwc_sec_agent.sv
// Secondary bus agent that raises parity and system error events on command
`timescale 1ns/1ns
module bwc_sec_agent (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic perr_cmd,
	input  wire logic serr_cmd,
	output logic      sec_parity_err,
	output logic      system_error_pin_n
);
	logic [1:0] low_q;
	// Parity pulse lasts one cycle; error pin held low two cycles, pulled up when idle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sec_parity_err <= 1'b0;
			low_q          <= 2'h0;
		end
		else
		begin
			sec_parity_err <= perr_cmd;
			low_q          <= serr_cmd ? 2'h2 : low_q - {1'b0, |low_q};
		end
	end
	assign system_error_pin_n = (low_q == 2'h0);
endmodule : bwc_sec_agent

// ===== testbench/tb.sv
// Self-checking bench for the bridge window configuration slice
`timescale 1ns/1ns
module tb;
	import bwc_pkg::*;
	typedef struct packed {logic [11:0] a; logic [31:0] rst; logic [31:0] ones;} bwc_row_t;
	logic         pclk     = 1'b0;
	logic         presetn  = 1'b0;
	bwc_apb_req_t req      = '0;
	bwc_apb_rsp_t rsp;
	bwc_io_req_t  io_lkp   = '0;
	bwc_mem_req_t mem_lkp  = '0;
	bwc_fwd_t     io_fwd;
	bwc_fwd_t     mem_fwd;
	logic         legacy   = 1'b0;
	logic         io_en    = 1'b0;
	logic         mem_en   = 1'b0;
	logic         perr_cmd = 1'b0;
	logic         serr_cmd = 1'b0;
	logic [3:0]   io_b     = 4'h0;
	logic [3:0]   io_l     = 4'h0;
	logic         perr_rep;
	logic         serr_req;
	logic         sec_perr;
	logic         serr_n;
	logic         er;
	logic [31:0]  rd;
	logic [31:0]  error_cnt   = '0;
	logic [31:0]  comparisons = '0;
	logic [31:0]  perr_cnt    = '0;
	logic [31:0]  serr_cnt    = '0;
	// Address, reset value, value after writing all ones
	bwc_row_t rows [8] = '{
		'{12'h020, 32'h0000_0000, 32'hfff0_fff0}, '{12'h024, 32'h0001_0001, 32'hfff1_fff1},
		'{12'h028, 32'h0000_0000, 32'hffff_ffff}, '{12'h02c, 32'h0000_0000, 32'hffff_ffff},
		'{12'h030, 32'h0000_0000, 32'hffff_ffff}, '{12'h034, 32'h0000_0080, 32'h0000_0080},
		'{12'h038, 32'h0000_0000, 32'h0000_0000}, '{12'h03c, 32'h0000_0100, 32'h001f_01ff}};

	always #50 pclk = ~pclk;

	bwc_regs i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.legacy_mode_in(legacy), .io_space_en(io_en), .mem_space_en(mem_en),
		.io_base_nibble(io_b), .io_limit_nibble(io_l), .io_lookup(io_lkp),
		.mem_lookup(mem_lkp), .io_fwd(io_fwd), .mem_fwd(mem_fwd),
		.sec_parity_err(sec_perr), .parity_err_report(perr_rep),
		.system_error_pin_n(serr_n), .syserr_msg_req(serr_req));

	bwc_sec_agent i_agent (.pclk(pclk), .presetn(presetn), .perr_cmd(perr_cmd),
		.serr_cmd(serr_cmd), .sec_parity_err(sec_perr), .system_error_pin_n(serr_n));

	// Event pulse counters
	always @(posedge pclk)
	begin
		perr_cnt <= perr_cnt + {31'h0, perr_rep === 1'b1};
		serr_cnt <= serr_cnt + {31'h0, serr_req === 1'b1};
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// One APB transfer, held until pready, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		req <= '{1'b1, 1'b0, w, a, d, s};
		@(posedge pclk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 16);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		@(posedge pclk);
		if (n >= 16)
			chk(32'h0, 32'h1);
	endtask : apb

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 4'hf);
		chk(rd, e);
	endtask : rdc

	task automatic setctl(input logic [4:0] b);
		apb(1'b1, 12'h03c, {11'h0, b, 16'h0}, 4'b0100);
	endtask : setctl

	task automatic io_chk(input logic [31:0] a, input logic [2:0] e);
		io_lkp <= '{1'b1, a};
		@(posedge pclk);
		io_lkp <= '0;
		@(posedge pclk);
		chk({29'h0, io_fwd}, {29'h0, e});
	endtask : io_chk

	task automatic mem_chk(input logic [63:0] a, input logic [2:0] e);
		mem_lkp <= '{1'b1, a};
		@(posedge pclk);
		mem_lkp <= '0;
		@(posedge pclk);
		chk({29'h0, mem_fwd}, {29'h0, e});
	endtask : mem_chk

	task automatic ev_chk(input logic [4:0] c, input logic ep, input logic es);
		logic [31:0] p0;
		logic [31:0] s0;
		setctl(c);
		p0 = perr_cnt;
		s0 = serr_cnt;
		perr_cmd <= 1'b1;
		serr_cmd <= 1'b1;
		@(posedge pclk);
		perr_cmd <= 1'b0;
		serr_cmd <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(perr_cnt - p0, {31'h0, ep});
		chk(serr_cnt - s0, {31'h0, es});
	endtask : ev_chk

	// Watchdog against a hung handshake
	initial
	begin
		repeat (5000) @(posedge pclk);
		error_cnt = error_cnt + 1;
		stop_test();
	end

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i])
		begin
			rdc(rows[i].a, rows[i].rst);
			apb(1'b1, rows[i].a, 32'hffff_ffff, 4'hf);
			rdc(rows[i].a, rows[i].ones);
		end
		apb(1'b1, 12'h030, 32'h1234_5678, 4'b0011);
		rdc(12'h030, 32'hffff_5678);
		apb(1'b1, 12'h03c, 32'h0000_00a5, 4'b0001);
		rdc(12'h03c, 32'h001f_01a5);
		apb(1'b1, 12'h040, 32'hffff_ffff, 4'hf);
		chk({31'h0, er}, 32'h1);
		rdc(12'h040, 32'h0);
		legacy <= 1'b1;
		repeat (4) @(posedge pclk);
		rdc(12'h034, 32'h0000_0090);
		// Second reset in mid-run restores defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(12'h03c, 32'h0000_0100);
		rdc(12'h024, 32'h0001_0001);
		apb(1'b1, 12'h020, 32'h0010_0010, 4'hf);
		apb(1'b1, 12'h024, 32'h0021_0021, 4'hf);
		apb(1'b1, 12'h028, 32'h0000_0001, 4'hf);
		apb(1'b1, 12'h02c, 32'h0000_0001, 4'hf);
		io_en <= 1'b1;
		mem_en <= 1'b1;
		io_l <= 4'hf;
		setctl(5'h00);
		io_chk(32'h0000_1100, 3'b110);
		setctl(5'h04);
		io_chk(32'h0000_1100, 3'b101);
		io_chk(32'h0000_1000, 3'b110);
		io_b <= 4'h1;
		io_l <= 4'h1;
		setctl(5'h00);
		io_chk(32'h0000_03c0, 3'b100);
		mem_chk(64'h000a_0000, 3'b100);
		setctl(5'h08);
		io_chk(32'h0000_03c0, 3'b110);
		mem_chk(64'h000a_0000, 3'b110);
		io_chk(32'h0000_23c0, 3'b110);
		setctl(5'h18);
		io_chk(32'h0000_23c0, 3'b100);
		setctl(5'h0c);
		io_chk(32'h0000_13c0, 3'b110);
		mem_chk(64'h1_0020_1234, 3'b110);
		mem_chk(64'h0_0020_1234, 3'b100);
		mem_chk(64'h0_001f_ffff, 3'b110);
		io_en <= 1'b0;
		mem_en <= 1'b0;
		io_chk(32'h0000_13c0, 3'b100);
		mem_chk(64'h000a_0000, 3'b100);
		ev_chk(5'h01, 1'b1, 1'b0);
		ev_chk(5'h02, 1'b0, 1'b1);
		ev_chk(5'h00, 1'b0, 1'b0);
		stop_test();
	end
endmodule : tb
